// ===== cdm_core.v
`timescale 1ns/1ns
`include "cdm_regs.vh"
// Operation
// - Opcode D7 copies the whole accumulator into the status register.
// - Opcode A3 reads program memory at current page, accumulator low byte.
// - Opcode E3 reads program memory page 0011, accumulator low byte.
// - External read drives pointer 0/1 address, loads returned byte into accumulator.
// - External write sends accumulator to address held in pointer 0/1.
// - Register swap exchanges accumulator with one of eight bank registers.
// - Indirect swap exchanges accumulator with RAM byte at pointer bits 0-5.
// - Nibble swap exchanges only low nibbles of accumulator and pointed byte.
// - Opcode A7 inverts carry, nothing else changes.
// - Separate inversions of user flag zero and one; flag one uses B5.
// - An instruction forces carry to zero, nothing else changes.
module cdm_core (
  input  wire        i_clk,        // 250 MHz core clock
  input  wire        i_rst,        // Async reset, active high
  input  wire        i_op_valid,   // Opcode offered
  input  wire [7:0]  i_opcode,     // Opcode byte
  output wire        o_ready,      // Core can take an opcode
  output reg         o_done,       // Instruction finished, one cycle
  input  wire [11:0] i_pc,         // Current program counter
  output reg  [11:0] o_pm_addr,    // Program memory address
  output reg         o_pm_rd,      // Program memory read strobe
  input  wire [7:0]  i_pm_data,    // Program memory byte, cycle after strobe
  output reg  [7:0]  o_xd_addr,    // External data address
  output reg  [7:0]  o_xd_wdata,   // External write data
  output reg         o_xd_rd,      // External read strobe
  output reg         o_xd_wr,      // External write strobe
  input  wire [7:0]  i_xd_rdata,   // External byte, cycle after read strobe
  input  wire        i_acc_load,   // Preload accumulator
  input  wire [7:0]  i_acc_wdata,  // Preload value
  input  wire        i_ram_wr,     // Preload internal RAM byte
  input  wire [5:0]  i_ram_addr,   // RAM preload or peek address
  input  wire [7:0]  i_ram_wdata,  // RAM preload value
  output reg  [7:0]  o_ram_rdata,  // RAM byte at i_ram_addr, registered
  output reg  [7:0]  o_acc,        // Accumulator
  output reg  [7:0]  o_psw,        // Processor status register
  output reg         o_flag_one    // User flag one
);

  // Sequencer states; three states do not pay for a one-hot code
  localparam ST_IDLE = 2'b00;
  localparam ST_PM   = 2'b01;
  localparam ST_XRD  = 2'b10;

  reg [1:0] state_q;
  reg [7:0] ram_q [0:63];
  integer   k;

  // RAM address of working register r in the active bank
  function [5:0] reg_addr;
    input       bs;
    input [2:0] r;
    begin
      reg_addr = bs ? (`CDM_BANK1_BASE | {3'b000, r}) : {3'b000, r};
    end
  endfunction

  // Upper nibble from one byte, lower nibble from another
  function [7:0] nib_merge;
    input [7:0] hi_src;
    input [7:0] lo_src;
    begin
      nib_merge = {hi_src[7:4], lo_src[3:0]};
    end
  endfunction

  // Operand locations in the active bank
  wire       take    = i_op_valid && o_ready;
  wire       bs      = o_psw[`CDM_PSW_BS];
  wire [5:0] r_loc   = reg_addr(bs, i_opcode[2:0]);
  wire [5:0] p_loc   = reg_addr(bs, {2'b00, i_opcode[0]});
  wire [7:0] p_val   = ram_q[p_loc];
  wire [5:0] ind_loc = p_val[5:0];
  wire [7:0] op_hi   = {i_opcode[7:1], 1'b0};
  wire [7:0] op_sw   = {i_opcode[7:3], 3'b000};
  wire [7:0] ind_val = ram_q[ind_loc];
  wire [7:0] reg_val = ram_q[r_loc];

  // Opcode decode; pointer forms match with the pointer bit masked
  wire       dec_psw_ld  = (i_opcode == `CDM_OP_PSW_LOAD);
  wire       dec_ptbl    = (i_opcode == `CDM_OP_PTBL);
  wire       dec_ptbl3   = (i_opcode == `CDM_OP_PTBL3);
  wire       dec_xrd     = (op_hi == `CDM_OP_XRD_BASE);
  wire       dec_xwr     = (op_hi == `CDM_OP_XWR_BASE);
  wire       dec_swreg   = (op_sw == `CDM_OP_SWAP_REG);
  wire       dec_swind   = (op_hi == `CDM_OP_SWAP_IND);
  wire       dec_nib     = (op_hi == `CDM_OP_NIB_BASE);
  wire       dec_inv_c   = (i_opcode == `CDM_OP_INV_C);
  wire       dec_inv_f0  = (i_opcode == `CDM_OP_INV_F0);
  wire       dec_inv_f1  = (i_opcode == `CDM_OP_INV_F1);
  wire       dec_zero_c  = (i_opcode == `CDM_OP_ZERO_C);
  wire       dec_zero_f0 = (i_opcode == `CDM_OP_ZERO_F0);
  wire       dec_zero_f1 = (i_opcode == `CDM_OP_ZERO_F1);

  // Only idle accepts; table and external reads hold the core one cycle
  assign o_ready = (state_q == ST_IDLE);

  // Execution sequencer
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_q    <= ST_IDLE;
      o_done     <= 1'b0;
      o_pm_addr  <= 12'h000;
      o_pm_rd    <= 1'b0;
      o_xd_addr  <= 8'h00;
      o_xd_wdata <= 8'h00;
      o_xd_rd    <= 1'b0;
      o_xd_wr    <= 1'b0;
      o_acc      <= `CDM_ACC_RST;
      o_psw      <= `CDM_PSW_RST;
      o_flag_one <= 1'b0;
      // RAM cleared so a pointer read after reset is defined
      for (k = 0; k < 64; k = k + 1)
        ram_q[k] <= 8'h00;
    end
    else
    begin
      o_done      <= 1'b0;
      o_pm_rd     <= 1'b0;
      o_xd_rd     <= 1'b0;
      o_xd_wr     <= 1'b0;
      // Preloads first, so an op on the same target in this edge wins
      if (i_acc_load)
        o_acc <= i_acc_wdata;
      if (i_ram_wr)
        ram_q[i_ram_addr] <= i_ram_wdata;
      case (state_q)
        // Table byte arrives one cycle after the strobe
        ST_PM:
        begin
          o_acc   <= i_pm_data;
          o_done  <= 1'b1;
          state_q <= ST_IDLE;
        end
        // External byte arrives one cycle after the strobe
        ST_XRD:
        begin
          o_acc   <= i_xd_rdata;
          o_done  <= 1'b1;
          state_q <= ST_IDLE;
        end
        // Idle: take a new opcode
        default:
        begin
          if (take)
          begin
            o_done <= 1'b1;
            if (dec_psw_ld)
              o_psw <= o_acc;
            else if (dec_ptbl)
            begin
              o_pm_addr <= {i_pc[11:8], o_acc};
              o_pm_rd   <= 1'b1;
              o_done    <= 1'b0;
              state_q   <= ST_PM;
            end
            else if (dec_ptbl3)
            begin
              o_pm_addr <= {`CDM_FIXED_PAGE, o_acc};
              o_pm_rd   <= 1'b1;
              o_done    <= 1'b0;
              state_q   <= ST_PM;
            end
            else if (dec_xrd)
            begin
              o_xd_addr <= p_val;
              o_xd_rd   <= 1'b1;
              o_done    <= 1'b0;
              state_q   <= ST_XRD;
            end
            else if (dec_xwr)
            begin
              o_xd_addr  <= p_val;
              o_xd_wdata <= o_acc;
              o_xd_wr    <= 1'b1;
            end
            else if (dec_swreg)
            begin
              o_acc        <= reg_val;
              ram_q[r_loc] <= o_acc;
            end
            else if (dec_swind)
            begin
              o_acc          <= ind_val;
              ram_q[ind_loc] <= o_acc;
            end
            else if (dec_nib)
            begin
              o_acc          <= nib_merge(o_acc, ind_val);
              ram_q[ind_loc] <= nib_merge(ind_val, o_acc);
            end
            else if (dec_inv_c)
              o_psw[`CDM_PSW_C] <= ~o_psw[`CDM_PSW_C];
            else if (dec_inv_f0)
              o_psw[`CDM_PSW_F0] <= ~o_psw[`CDM_PSW_F0];
            else if (dec_inv_f1)
              o_flag_one <= ~o_flag_one;
            else if (dec_zero_c)
              o_psw[`CDM_PSW_C] <= 1'b0;
            else if (dec_zero_f0)
              o_psw[`CDM_PSW_F0] <= 1'b0;
            else if (dec_zero_f1)
              o_flag_one <= 1'b0;
          end
        end
      endcase
    end
  end

  // Registered peek port; one cycle late, never combinational off RAM
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      o_ram_rdata <= 8'h00;
    else
      o_ram_rdata <= ram_q[i_ram_addr];
  end

endmodule // cdm_core

// ===== cdm_core_properties.sv
`timescale 1ns/1ns
// Bus strobe, flag and status effects of opcodes taken at the port
module cdm_core_properties (
  input wire       i_clk,      // Clock
  input wire       i_rst,      // Reset
  input wire       i_op_valid, // Offer
  input wire [7:0] i_opcode,   // Opcode
  input wire [11:0] i_pc,      // Program counter
  input wire [11:0] o_pm_addr, // Table address
  input wire       o_pm_rd,    // Table strobe
  input wire       o_xd_rd,    // Read strobe
  input wire       o_ready,    // Idle
  input wire [7:0] o_xd_wdata, // Wdata
  input wire       o_xd_wr,    // Wstrobe
  input wire [7:0] o_acc,      // Acc
  input wire [7:0] o_psw,      // Status
  input wire       o_flag_one  // Flag one
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Opcode taken at this edge, flagged in bit 8
  wire [8:0] tk = {i_op_valid && o_ready, i_opcode};
  wire [3:0] pc_page = i_pc[11:8];
  a_page_read: assert property (tk == 9'h1A3 |=>
    o_pm_rd && o_pm_addr == {$past(pc_page), $past(o_acc)}) else $error("page read");
  a_fixed_page: assert property (tk == 9'h1E3 |=>
    o_pm_rd && o_pm_addr == {4'h3, $past(o_acc)}) else $error("fixed page");
  a_ext_read: assert property (tk[8:1] == 8'hC0 |=> o_xd_rd && !o_xd_wr)
    else $error("ext read");
  a_status_load: assert property (tk == 9'h1D7 |=> o_psw == $past(o_acc))
    else $error("status load");
  a_carry_inv: assert property (tk == 9'h1A7 |=> o_psw == ($past(o_psw) ^ 8'h80))
    else $error("carry inv");
  a_flag0_inv: assert property (tk == 9'h195 |=> o_psw == ($past(o_psw) ^ 8'h20))
    else $error("flag0 inv");
  a_flag1_inv: assert property (tk == 9'h1B5 |=> o_flag_one != $past(o_flag_one))
    else $error("flag1 inv");
  a_carry_zero: assert property (tk == 9'h197 |=> o_psw == ($past(o_psw) & 8'h7F))
    else $error("carry zero");
  a_flag0_zero: assert property (tk == 9'h185 |=> o_psw == ($past(o_psw) & 8'hDF))
    else $error("flag0 zero");
  a_flag1_zero: assert property (tk == 9'h1A5 |=> !o_flag_one && $stable(o_psw))
    else $error("flag1 zero");
  a_ext_write: assert property (tk[8:1] == 8'hC8 |=> o_xd_wr && o_xd_wdata == $past(o_acc))
    else $error("ext write");
  cover property (tk == 9'h1D7);
  cover property (tk == 9'h1E3);
  cover property (o_xd_wr);
  cover property (o_xd_rd);
endmodule // cdm_core_properties
bind cdm_core cdm_core_properties cdm_core_properties_inst (.*);

// ===== cdm_regs.vh
`ifndef CDM_REGS_VH
`define CDM_REGS_VH

// Opcode encodings
`define CDM_OP_PSW_LOAD   8'h0D7
`define CDM_OP_PTBL       8'h0A3
`define CDM_OP_PTBL3      8'h0E3
`define CDM_OP_XRD_BASE   8'h080
`define CDM_OP_XWR_BASE   8'h090
`define CDM_OP_SWAP_IND   8'h020
`define CDM_OP_SWAP_REG   8'h028
`define CDM_OP_NIB_BASE   8'h030
`define CDM_OP_INV_C      8'h0A7
`define CDM_OP_INV_F0     8'h095
`define CDM_OP_INV_F1     8'h0B5
`define CDM_OP_ZERO_C     8'h097
`define CDM_OP_ZERO_F0    8'h085
`define CDM_OP_ZERO_F1    8'h0A5

// Status register field positions
`define CDM_PSW_C         7
`define CDM_PSW_F0        5
`define CDM_PSW_BS        4

// Fixed table page for the page-3 read
`define CDM_FIXED_PAGE    4'h3

// Bank 1 working register base in internal RAM
`define CDM_BANK1_BASE    6'h18

// Reset values
`define CDM_ACC_RST       8'h00
`define CDM_PSW_RST       8'h08

`endif

// ===== cdm_xmem.sv
`timescale 1ns/1ns
// External data memory; an unread bus toggles so stale data cannot pass
module cdm_xmem (
  input  wire       i_clk, // Clock
  input  wire       i_rd,  // Read
  input  wire       i_wr,  // Write
  input  wire [7:0] i_a,   // Address
  input  wire [7:0] i_d,   // Data in
  output wire [7:0] o_q    // Data out
);
  reg [7:0] mem_q [0:255];
  reg [7:0] junk_q = 8'h5A;
  assign o_q = i_rd ? mem_q[i_a] : junk_q;
  // Store on strobe
  always @(posedge i_clk)
  begin
    junk_q <= ~junk_q;
    if (i_wr) mem_q[i_a] <= i_d;
  end
endmodule // cdm_xmem

// ===== testbench.sv
`timescale 1ns/1ns
module testbench;
  reg         i_clk = 0, i_rst = 1, i_op_valid = 0, i_acc_load = 0, i_ram_wr = 0;
  reg  [7:0]  i_opcode = 8'h00, i_acc_wdata = 8'h00, i_ram_wdata = 8'h00;
  reg  [5:0]  i_ram_addr = 6'h00;
  reg  [11:0] i_pc = 12'h500;
  wire        o_ready, o_done, o_pm_rd, o_xd_rd, o_xd_wr, o_flag_one;
  wire [7:0]  o_xd_addr, o_xd_wdata, i_xd_rdata, o_ram_rdata, o_acc, o_psw;
  wire [11:0] o_pm_addr;
  // Table memory byte derived from its own address
  wire [7:0]  i_pm_data = o_pm_addr[11:4] ^ o_pm_addr[7:0];
  integer     error_cnt = 0, total_checks = 0, k, n;
  // Flag opcodes and the status value expected after each
  reg  [31:0] ops = 32'hA795_9785, exps = 32'h80A0_2000;
  cdm_core cdm_core_inst (
    .i_clk       (i_clk),
    .i_rst       (i_rst),
    .i_op_valid  (i_op_valid),
    .i_opcode    (i_opcode),
    .o_ready     (o_ready),
    .o_done      (o_done),
    .i_pc        (i_pc),
    .o_pm_addr   (o_pm_addr),
    .o_pm_rd     (o_pm_rd),
    .i_pm_data   (i_pm_data),
    .o_xd_addr   (o_xd_addr),
    .o_xd_wdata  (o_xd_wdata),
    .o_xd_rd     (o_xd_rd),
    .o_xd_wr     (o_xd_wr),
    .i_xd_rdata  (i_xd_rdata),
    .i_acc_load  (i_acc_load),
    .i_acc_wdata (i_acc_wdata),
    .i_ram_wr    (i_ram_wr),
    .i_ram_addr  (i_ram_addr),
    .i_ram_wdata (i_ram_wdata),
    .o_ram_rdata (o_ram_rdata),
    .o_acc       (o_acc),
    .o_psw       (o_psw),
    .o_flag_one  (o_flag_one)
  );
  cdm_xmem cdm_xmem_inst (.i_clk(i_clk), .i_rd(o_xd_rd), .i_wr(o_xd_wr), .i_a(o_xd_addr),
    .i_d(o_xd_wdata), .o_q(i_xd_rdata));
  initial forever #2 i_clk = ~i_clk;
  task give_verdict;
  begin
    if (error_cnt == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  end
  endtask
  task chk(input [7:0] g, input [7:0] e);
  begin
    total_checks = total_checks + 1;
    if (g !== e) error_cnt = error_cnt + 1;
    if (g !== e) $display("CHECK FAILED %0t %h %h", $time, g, e);
  end
  endtask
  // Offer one opcode, then wait a bounded time for done
  task run(input [7:0] op);
  begin
    @(negedge i_clk) {i_op_valid, i_opcode} = {1'b1, op};
    @(negedge i_clk) i_op_valid = 0;
    for (n = 0; n < 3 && o_done !== 1'b1; n = n + 1) @(negedge i_clk);
  end
  endtask
  // Preload RAM byte (r set) or accumulator
  task ld(input r, input [5:0] a, input [7:0] d);
  begin
    @(negedge i_clk) {i_acc_load, i_ram_wr, i_ram_addr, i_ram_wdata, i_acc_wdata} = {~r, r, a, d, d};
    @(negedge i_clk) {i_acc_load, i_ram_wr} = 2'b00;
  end
  endtask
  // Compare an internal RAM byte through the registered peek port
  task peek(input [5:0] a, input [7:0] e);
  begin
    @(negedge i_clk) i_ram_addr = a;
    @(negedge i_clk) chk(o_ram_rdata, e);
  end
  endtask
  initial
  begin
    repeat (12) @(posedge i_clk);
    @(negedge i_clk) i_rst = 0;
    chk(o_psw, 8'h08);
    ld(0, 6'h00, 8'h5A);
    run(8'hD7);
    chk(o_psw, 8'h5A);
    ld(0, 6'h00, 8'h00);
    run(8'hD7);
    chk(o_psw, 8'h00);
    for (k = 3; k >= 0; k = k - 1)
    begin
      run(ops[8 * k +: 8]);
      chk(o_psw, exps[8 * k +: 8]);
    end
    run(8'hB5);
    chk({7'h00, o_flag_one}, 8'h01);
    run(8'hA5);
    chk({7'h00, o_flag_one}, 8'h00);
    chk(o_acc, 8'h00);
    ld(1, 6'h00, 8'h10);
    ld(1, 6'h01, 8'h21);
    ld(1, 6'h02, 8'h99);
    ld(1, 6'h10, 8'h3C);
    ld(0, 6'h00, 8'hC7);
    run(8'h20);
    chk(o_acc, 8'h3C);
    peek(6'h10, 8'hC7);
    run(8'h30);
    chk(o_acc, 8'h37);
    peek(6'h10, 8'hCC);
    run(8'h20);
    chk(o_acc, 8'hCC);
    run(8'h2A);
    chk(o_acc, 8'h99);
    peek(6'h02, 8'hCC);
    run(8'h91);
    ld(0, 6'h00, 8'h00);
    run(8'h81);
    chk(o_acc, 8'h99);
    chk(o_xd_addr, 8'h21);
    ld(0, 6'h00, 8'h4E);
    run(8'hE3);
    chk(o_acc, 8'h7A);
    chk({4'h0, o_pm_addr[11:8]}, 8'h03);
    run(8'hA3);
    chk(o_acc, 8'h2D);
    chk({4'h0, o_pm_addr[11:8]}, {4'h0, i_pc[11:8]});
    chk(o_pm_addr[7:0], 8'h7A);
    // Bank one moves register and pointer fields to the upper bank
    ld(1, 6'h18, 8'h6B);
    ld(1, 6'h19, 8'h21);
    ld(0, 6'h00, 8'h10);
    run(8'hD7);
    run(8'h28);
    chk(o_acc, 8'h6B);
    peek(6'h18, 8'h10);
    run(8'h81);
    chk(o_acc, 8'h99);
    give_verdict;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    #4000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
endmodule // testbench
